// [buart_consts.vh]
// Constants for the banked serial port register front end
`ifndef BUART_CONSTS_VH
`define BUART_CONSTS_VH
// Register indices inside the window, byte address is index * 4
`define BUART_OFF_0 4'h0
`define BUART_OFF_1 4'h1
`define BUART_OFF_2 4'h2
`define BUART_OFF_3 4'h3
`define BUART_OFF_4 4'h4
`define BUART_OFF_5 4'h5
`define BUART_OFF_6 4'h6
`define BUART_OFF_7 4'h7
`define BUART_IDX_IRQ_STAT 4'h8
`define BUART_IDX_IRQ_MASK 4'h9
// Bank numbers, NONE for undefined select codes
`define BUART_BANK0 4'h0
`define BUART_BANK1 4'h1
`define BUART_BANK2 4'h2
`define BUART_BANK3 4'h3
`define BUART_BANK_NONE 4'hF
// Upper select bits 5:2 for banks 2 to 7
`define BUART_SEL_B2 4'h8
`define BUART_SEL_B3 4'h9
`define BUART_SEL_B4 4'hA
`define BUART_SEL_B5 4'hB
`define BUART_SEL_B6 4'hC
`define BUART_SEL_B7 4'hD
// Field positions
`define BUART_BIT_BANK_SELECT_ENABLE_BIT 7
`define BUART_BIT_EXT_SL 0
`define BUART_BIT_XLOOP 4
`define BUART_BIT_LOOP 4
`define BUART_BIT_FIFO_EN 0
`define BUART_BIT_RXSR 1
`define BUART_BIT_TXSR 2
`define BUART_BIT_TXEMP_IE 5
// Classic event codes
`define BUART_EV_NONE 3'h1
`define BUART_EV_LS 3'h6
`define BUART_EV_RX 3'h4
`define BUART_EV_TX 3'h2
`define BUART_EV_MS 3'h0
// Reset values
`define BUART_RST_BYTE 8'h00
`define BUART_RST_DIV 8'h00
`define BUART_RST_NIB 4'h0
// Identity nibbles, arbitrary values
`define BUART_MODULE_ID 4'h5
`define BUART_REV_ID 4'h1
`endif

// [buart_partner.sv]
// Serial engine and modem pins seen from the far side of the block
`timescale 1ns/1ps
module buart_partner (
   input wire hclk,
   input wire [7:0] tx_byte,
   input wire tx_load,
   output reg [7:0] rx_byte,
   output reg rx_byte_valid,
   output reg rx_overrun,
   output reg rx_parity_err,
   output reg rx_frame_err,
   output reg rx_break,
   output reg tx_ready,
   output reg tx_empty,
   output reg cts_pin,
   output reg dsr_pin,
   output reg dcd_pin,
   output reg ri_pin
);
   reg [7:0] last_tx = 8'h00;
   reg [2:0] busy = 3'h0;
   initial begin
      rx_byte = 8'h00;
      {rx_byte_valid, rx_overrun, rx_parity_err} = 3'h0;
      {rx_frame_err, rx_break, tx_ready, tx_empty} = 4'h3;
      {cts_pin, dsr_pin, dcd_pin, ri_pin} = 4'h0;
   end
   // Slow transmitter: busy for a few cycles after each load
   always @(posedge hclk) begin
      if (tx_load) begin
         last_tx <= tx_byte;
         busy <= 3'h4;
      end else if (busy != 3'h0) begin
         busy <= busy - 3'h1;
      end
      tx_ready <= !tx_load && busy <= 3'h1;
      tx_empty <= !tx_load && busy == 3'h0;
   end
   task send_rx(input [7:0] b);
      begin
         @(posedge hclk);
         rx_byte <= b;
         rx_byte_valid <= 1'b1;
         @(posedge hclk);
         rx_byte <= ~b;
         rx_byte_valid <= 1'b0;
      end
   endtask
   task pulse_err(input [3:0] e);
      begin
         @(posedge hclk);
         {rx_break, rx_frame_err, rx_parity_err, rx_overrun} <= e;
         @(posedge hclk);
         {rx_break, rx_frame_err, rx_parity_err, rx_overrun} <= 4'h0;
      end
   endtask
   task set_modem(input [3:0] m);
      begin
         @(posedge hclk);
         {dcd_pin, ri_pin, dsr_pin, cts_pin} <= m;
      end
   endtask
endmodule

// [buart_regs.v]
// Banked serial port register front end with AHB-Lite slave
`timescale 1ns/1ps
`include "buart_consts.vh"
module buart_regs (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   output reg irq,
   input wire [7:0] rx_byte,
   input wire rx_byte_valid,
   input wire rx_overrun,
   input wire rx_parity_err,
   input wire rx_frame_err,
   input wire rx_break,
   input wire tx_ready,
   input wire tx_empty,
   input wire cts_pin,
   input wire dsr_pin,
   input wire dcd_pin,
   input wire ri_pin,
   output reg [7:0] tx_byte,
   output reg tx_load,
   output reg rx_taken,
   output reg rx_queue_reset,
   output reg tx_queue_reset,
   output reg [7:0] queue_ctrl_shadow,
   output reg [7:0] line_ctrl,
   output reg [15:0] baud_divisor,
   output reg ext_mode,
   output reg loop_mode,
   output reg rts_out,
   output reg dtr_out
);
   // Bus phase tracking
   reg rd_pend;
   reg wr_pend;
   reg [3:0] rd_idx;
   reg [3:0] wr_idx;
   reg rd_hit;
   reg wr_hit;
   // Port registers
   reg [7:0] bank_select;
   reg [7:0] irq_enable;
   reg [7:0] modem_mode_ctrl;
   reg [7:0] scratch_aux_ctrl;
   reg [7:0] legacy_divisor_low;
   reg [7:0] legacy_divisor_high;
   reg [7:0] divisor_low;
   reg [7:0] divisor_high;
   reg [7:0] extended_ctrl_one;
   reg [7:0] extended_ctrl_two;
   reg [4:0] tx_queue_level;
   reg [4:0] rx_queue_level;
   // Receive and status state
   reg [7:0] rx_hold;
   reg rxda;
   reg err_oe;
   reg err_pe;
   reg err_fe;
   reg err_bi;
   reg [3:0] m_prev;
   reg [3:0] m_delta;
   reg [3:0] irq_status;
   reg [3:0] irq_mask;
   reg [3:0] ev_prev;
   reg [7:0] rd_value;
   reg [7:0] event_ident;
   reg [2:0] ev_code;

   wire [3:0] m_now;
   wire accept;
   wire [3:0] bank;
   wire ext;
   wire wr_r;
   wire [7:0] wd;
   wire [7:0] link_stat;
   wire [7:0] modem_stat;
   wire [7:0] line_ctrl_shadow;
   wire [7:0] module_revision;
   wire ls_c;
   wire ms_c;
   wire [3:0] ev_now;
   wire [3:0] ev_rise;
   wire [3:0] stat_clr;
   wire [3:0] next_irq_status;
   wire rd_rx;
   wire rd_lsr;
   wire rd_msr;
   wire we_data;
   wire we_qctl;

   // Selector code to bank number
   function [3:0] bank_of;
      input [7:0] b;
      begin
         if (!b[7]) begin
            bank_of = `BUART_BANK0;
         end else if (!b[6] || b[1] || b[0]) begin
            bank_of = `BUART_BANK1;
         end else begin
            case (b[5:2])
               `BUART_SEL_B2: bank_of = `BUART_BANK2;
               `BUART_SEL_B3: bank_of = `BUART_BANK3;
               `BUART_SEL_B4: bank_of = 4'h4;
               `BUART_SEL_B5: bank_of = 4'h5;
               `BUART_SEL_B6: bank_of = 4'h6;
               `BUART_SEL_B7: bank_of = 4'h7;
               default: bank_of = `BUART_BANK_NONE;
            endcase
         end
      end
   endfunction

   buart_sync3 #(
      .WIDTH(4)
   ) u_modem_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in({dcd_pin, ri_pin, dsr_pin, cts_pin}),
      .pin_out(m_now)
   );

   assign accept = hsel & htrans[1] & hready;
   assign bank = bank_of(bank_select);
   assign ext = extended_ctrl_one[`BUART_BIT_EXT_SL];
   assign wr_r = wr_pend & wr_hit;
   assign wd = hwdata[7:0];
   assign we_data = wr_r && bank == `BUART_BANK0 && wr_idx == `BUART_OFF_0;
   assign we_qctl = wr_r && bank == `BUART_BANK0 && wr_idx == `BUART_OFF_2;
   assign rd_rx = rd_pend && rd_hit && bank == `BUART_BANK0 &&
      rd_idx == `BUART_OFF_0;
   assign rd_lsr = rd_pend && rd_hit && bank == `BUART_BANK0 &&
      rd_idx == `BUART_OFF_5;
   assign rd_msr = rd_pend && rd_hit && bank == `BUART_BANK0 &&
      rd_idx == `BUART_OFF_6;
   assign ls_c = err_oe | err_pe | err_fe | err_bi;
   assign ms_c = |m_delta;
   assign link_stat = {ls_c, tx_empty, tx_ready, err_bi, err_fe, err_pe,
      err_oe, rxda};
   assign modem_stat = {m_prev, m_delta};
   assign line_ctrl_shadow = {bank_select[`BUART_BIT_BANK_SELECT_ENABLE_BIT],
      line_ctrl[6:0]};
   assign module_revision = {`BUART_MODULE_ID, `BUART_REV_ID};
   assign ev_now = {ms_c, ls_c, tx_ready, rxda} & irq_enable[3:0];
   assign ev_rise = ev_now & ~ev_prev;
   assign stat_clr = (wr_r && wr_idx == `BUART_IDX_IRQ_STAT) ?
      wd[3:0] : 4'h0;
   assign next_irq_status = (irq_status & ~stat_clr) | ev_rise;

   // Address phase capture, reads take one wait state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_pend <= 1'b0;
         wr_pend <= 1'b0;
         rd_idx <= 4'h0;
         wr_idx <= 4'h0;
         rd_hit <= 1'b0;
         wr_hit <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         rd_pend <= accept & ~hwrite;
         wr_pend <= accept & hwrite;
         if (accept) begin
            rd_idx <= haddr[5:2];
            wr_idx <= haddr[5:2];
            rd_hit <= haddr[31:6] == 26'h0 && haddr[1:0] == 2'h0;
            wr_hit <= haddr[31:6] == 26'h0 && haddr[1:0] == 2'h0;
         end
         if (accept & ~hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_pend) begin
            hreadyout <= 1'b1;
         end
      end
   end

   // Classic event priority code
   always @* begin
      if (ls_c && irq_enable[2]) begin
         ev_code = `BUART_EV_LS;
      end else if (rxda && irq_enable[0]) begin
         ev_code = `BUART_EV_RX;
      end else if (tx_ready && irq_enable[1]) begin
         ev_code = `BUART_EV_TX;
      end else if (ms_c && irq_enable[3]) begin
         ev_code = `BUART_EV_MS;
      end else begin
         ev_code = `BUART_EV_NONE;
      end
      if (ext) begin
         event_ident = {2'b00,
            tx_empty & irq_enable[`BUART_BIT_TXEMP_IE], 1'b0,
            ev_now};
      end else begin
         event_ident = {{2{queue_ctrl_shadow[`BUART_BIT_FIFO_EN]}},
            3'h0, ev_code};
      end
   end

   // Read mux by bank and offset
   always @* begin
      rd_value = 8'h00;
      if (rd_hit) begin
         if (rd_idx == `BUART_OFF_3) begin
            rd_value = bank_select[`BUART_BIT_BANK_SELECT_ENABLE_BIT] ? bank_select :
               line_ctrl;
         end else if (rd_idx == `BUART_IDX_IRQ_STAT) begin
            rd_value = {4'h0, irq_status};
         end else if (rd_idx == `BUART_IDX_IRQ_MASK) begin
            rd_value = {4'h0, irq_mask};
         end else begin
            case (bank)
               `BUART_BANK0: begin
                  case (rd_idx)
                     `BUART_OFF_0: rd_value = rx_hold;
                     `BUART_OFF_1: rd_value = ext ? irq_enable :
                        {4'h0, irq_enable[3:0]};
                     `BUART_OFF_2: rd_value = event_ident;
                     `BUART_OFF_4: rd_value = ext ?
                        {4'h0, modem_mode_ctrl[3], 1'b0,
                        modem_mode_ctrl[1:0]} :
                        {3'h0, modem_mode_ctrl[4:0]};
                     `BUART_OFF_5: rd_value = link_stat;
                     `BUART_OFF_6: rd_value = modem_stat;
                     `BUART_OFF_7: rd_value = scratch_aux_ctrl;
                     default: rd_value = 8'h00;
                  endcase
               end
               `BUART_BANK1: begin
                  case (rd_idx)
                     `BUART_OFF_0: rd_value = legacy_divisor_low;
                     `BUART_OFF_1: rd_value = legacy_divisor_high;
                     default: rd_value = 8'h00;
                  endcase
               end
               `BUART_BANK2: begin
                  case (rd_idx)
                     `BUART_OFF_0: rd_value = divisor_low;
                     `BUART_OFF_1: rd_value = divisor_high;
                     `BUART_OFF_2: rd_value = extended_ctrl_one;
                     `BUART_OFF_4: rd_value = extended_ctrl_two;
                     `BUART_OFF_6: rd_value = {3'h0, tx_queue_level};
                     `BUART_OFF_7: rd_value = {3'h0, rx_queue_level};
                     default: rd_value = 8'h00;
                  endcase
               end
               `BUART_BANK3: begin
                  case (rd_idx)
                     `BUART_OFF_0: rd_value = module_revision;
                     `BUART_OFF_1: rd_value = line_ctrl_shadow;
                     `BUART_OFF_2: rd_value = queue_ctrl_shadow;
                     default: rd_value = 8'h00;
                  endcase
               end
               default: rd_value = 8'h00;
            endcase
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_pend) begin
         hrdata <= {24'h000000, rd_value};
      end
   end

   // Line control and bank select share offset 03h
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_select <= `BUART_RST_BYTE;
         line_ctrl <= `BUART_RST_BYTE;
      end else if (wr_r && wr_idx == `BUART_OFF_3) begin
         bank_select <= wd;
         if (!wd[`BUART_BIT_BANK_SELECT_ENABLE_BIT]) begin
            line_ctrl <= wd;
         end
      end
   end

   // Banked register writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_enable <= `BUART_RST_BYTE;
         modem_mode_ctrl <= `BUART_RST_BYTE;
         scratch_aux_ctrl <= `BUART_RST_BYTE;
         legacy_divisor_low <= `BUART_RST_DIV;
         legacy_divisor_high <= `BUART_RST_DIV;
         divisor_low <= `BUART_RST_DIV;
         divisor_high <= `BUART_RST_DIV;
         extended_ctrl_one <= `BUART_RST_BYTE;
         extended_ctrl_two <= `BUART_RST_BYTE;
         tx_queue_level <= 5'h00;
         rx_queue_level <= 5'h00;
         queue_ctrl_shadow <= `BUART_RST_BYTE;
         irq_mask <= `BUART_RST_NIB;
      end else if (wr_r) begin
         if (wr_idx == `BUART_IDX_IRQ_MASK) begin
            irq_mask <= wd[3:0];
         end
         case (bank)
            `BUART_BANK0: begin
               case (wr_idx)
                  `BUART_OFF_1: irq_enable <= wd;
                  `BUART_OFF_2: queue_ctrl_shadow <= wd;
                  `BUART_OFF_4: modem_mode_ctrl <= wd;
                  `BUART_OFF_7: scratch_aux_ctrl <= wd;
                  default: ;
               endcase
            end
            `BUART_BANK1: begin
               case (wr_idx)
                  `BUART_OFF_0: legacy_divisor_low <= wd;
                  `BUART_OFF_1: legacy_divisor_high <= wd;
                  default: ;
               endcase
            end
            `BUART_BANK2: begin
               case (wr_idx)
                  `BUART_OFF_0: divisor_low <= wd;
                  `BUART_OFF_1: divisor_high <= wd;
                  `BUART_OFF_2: extended_ctrl_one <= wd;
                  `BUART_OFF_4: extended_ctrl_two <= wd;
                  `BUART_OFF_6: tx_queue_level <= wd[4:0];
                  `BUART_OFF_7: rx_queue_level <= wd[4:0];
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   // Engine-facing strobes and settings
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_byte <= `BUART_RST_BYTE;
         tx_load <= 1'b0;
         rx_taken <= 1'b0;
         rx_queue_reset <= 1'b0;
         tx_queue_reset <= 1'b0;
         baud_divisor <= 16'h0000;
         ext_mode <= 1'b0;
         loop_mode <= 1'b0;
         rts_out <= 1'b0;
         dtr_out <= 1'b0;
      end else begin
         tx_load <= we_data;
         if (we_data) begin
            tx_byte <= wd;
         end
         rx_taken <= rd_rx;
         rx_queue_reset <= we_qctl & wd[`BUART_BIT_RXSR];
         tx_queue_reset <= we_qctl & wd[`BUART_BIT_TXSR];
         baud_divisor <= ext ? {divisor_high, divisor_low} :
            {legacy_divisor_high, legacy_divisor_low};
         ext_mode <= ext;
         loop_mode <= ext ? extended_ctrl_one[`BUART_BIT_XLOOP] :
            modem_mode_ctrl[`BUART_BIT_LOOP];
         rts_out <= modem_mode_ctrl[1];
         dtr_out <= modem_mode_ctrl[0];
      end
   end

   // Receive holding byte and line errors, set wins over clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_hold <= `BUART_RST_BYTE;
         rxda <= 1'b0;
         err_oe <= 1'b0;
         err_pe <= 1'b0;
         err_fe <= 1'b0;
         err_bi <= 1'b0;
      end else begin
         if (rx_byte_valid) begin
            rx_hold <= rx_byte;
            rxda <= 1'b1;
         end else if (rd_rx) begin
            rxda <= 1'b0;
         end
         if (rx_overrun || (rx_byte_valid && rxda && !rd_rx)) begin
            err_oe <= 1'b1;
         end else if (rd_lsr) begin
            err_oe <= 1'b0;
         end
         if (rx_parity_err) begin
            err_pe <= 1'b1;
         end else if (rd_lsr) begin
            err_pe <= 1'b0;
         end
         if (rx_frame_err) begin
            err_fe <= 1'b1;
         end else if (rd_lsr) begin
            err_fe <= 1'b0;
         end
         if (rx_break) begin
            err_bi <= 1'b1;
         end else if (rd_lsr) begin
            err_bi <= 1'b0;
         end
      end
   end

   // Modem line deltas; bit 2 marks ring trailing edge
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         m_prev <= `BUART_RST_NIB;
         m_delta <= `BUART_RST_NIB;
      end else begin
         m_prev <= m_now;
         m_delta[3] <= (m_now[3] ^ m_prev[3]) | (m_delta[3] & ~rd_msr);
         m_delta[2] <= (m_prev[2] & ~m_now[2]) | (m_delta[2] & ~rd_msr);
         m_delta[1] <= (m_now[1] ^ m_prev[1]) | (m_delta[1] & ~rd_msr);
         m_delta[0] <= (m_now[0] ^ m_prev[0]) | (m_delta[0] & ~rd_msr);
      end
   end

   // Sticky interrupt status, write one to clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_prev <= `BUART_RST_NIB;
         irq_status <= `BUART_RST_NIB;
         irq <= 1'b0;
      end else begin
         ev_prev <= ev_now;
         irq_status <= next_irq_status;
         irq <= |(next_irq_status & irq_mask);
      end
   end
endmodule

// [buart_regs_asserts.sv]
// Assertion checker for the banked serial port register front end
`timescale 1ns/1ps
module buart_regs_asserts (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire [7:0] tx_byte,
   input wire tx_load,
   input wire rx_taken,
   input wire rx_queue_reset,
   input wire tx_queue_reset,
   input wire [7:0] queue_ctrl_shadow,
   input wire [7:0] line_ctrl,
   input wire [15:0] baud_divisor,
   input wire ext_mode
);
   reg ar;
   reg aw;
   reg dw;
   reg [3:0] aidx;
   reg [3:0] didx;
   reg [7:0] dd;
   reg [7:0] sel;
   reg [7:0] dsel;
   wire take = hsel & htrans[1] & hready & (haddr[31:6] == 26'h0) &
      (haddr[1:0] == 2'h0);
   wire bank1 = dsel[7] & (~dsel[6] | dsel[1] | dsel[0]);
   // Follows the bus and the bank select value as the slave sees them
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ar <= 1'b0;
         aw <= 1'b0;
         dw <= 1'b0;
         aidx <= 4'h0;
         didx <= 4'h0;
         dd <= 8'h00;
         sel <= 8'h00;
         dsel <= 8'h00;
      end else begin
         ar <= take & ~hwrite;
         aw <= take & hwrite;
         dw <= aw;
         aidx <= haddr[5:2];
         didx <= aidx;
         dd <= hwdata[7:0];
         dsel <= sel;
         if (aw && aidx == 4'h3) begin
            sel <= hwdata[7:0];
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence rd_wait_s;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence rd_done_s;
      ar ##0 rd_wait_s;
   endsequence
   okay_resp_a: assert property (!hresp)
      else $error("response not okay");
   read_wait_a: assert property (ar |-> rd_wait_s)
      else $error("read data phase not one wait cycle");
   write_nowait_a: assert property (aw |-> hreadyout)
      else $error("write data phase stalled");
   byte_read_a: assert property (rd_done_s |-> hrdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   line_upd_a: assert property (dw && didx == 4'h3 && !dd[7] |->
      line_ctrl == dd)
      else $error("line control not updated");
   line_keep_a: assert property (dw && didx == 4'h3 && dd[7] |->
      $stable(line_ctrl))
      else $error("line control changed by bank select");
   queue_shadow_a: assert property (dw && didx == 4'h2 && !dsel[7] |->
      queue_ctrl_shadow == dd && rx_queue_reset == dd[1] &&
      tx_queue_reset == dd[2])
      else $error("queue control write not reflected");
   tx_load_a: assert property (dw && didx == 4'h0 && !dsel[7] |->
      tx_load && tx_byte == dd)
      else $error("data port write not loaded");
   legacy_div_a: assert property (dw && didx == 4'h1 && bank1 &&
      !ext_mode |=> baud_divisor[15:8] == $past(dd))
      else $error("legacy divisor high byte wrong");
   rx_taken_a: assert property (ar && aidx == 4'h0 && !sel[7] |->
      ##[1:3] rx_taken)
      else $error("data port read not reported");
endmodule
bind buart_regs buart_regs_asserts buart_regs_asserts_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .tx_byte(tx_byte), .tx_load(tx_load), .rx_taken(rx_taken),
   .rx_queue_reset(rx_queue_reset), .tx_queue_reset(tx_queue_reset),
   .queue_ctrl_shadow(queue_ctrl_shadow), .line_ctrl(line_ctrl),
   .baud_divisor(baud_divisor), .ext_mode(ext_mode));

// [buart_sync3.v]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module buart_sync3 #(
   parameter WIDTH = 4
) (
   input wire hclk,
   input wire hresetn,
   input wire [WIDTH-1:0] pin_in,
   output reg [WIDTH-1:0] pin_out
);
   reg [WIDTH-1:0] s1;
   reg [WIDTH-1:0] s2;
   reg [WIDTH-1:0] s3;
   integer i;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1 <= {WIDTH{1'b0}};
         s2 <= {WIDTH{1'b0}};
         s3 <= {WIDTH{1'b0}};
         pin_out <= {WIDTH{1'b0}};
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
         for (i = 0; i < WIDTH; i = i + 1) begin
            if (s2[i] == s3[i]) begin
               pin_out[i] <= s3[i];
            end
         end
      end
   end
endmodule

// [test_banked_uart_register_access.sv]
// Self-checking bench for the banked serial port register front end
`timescale 1ns/1ps
`include "buart_consts.vh"
`define CHK(g, e) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
   failures = failures + 1; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_banked_uart_register_access;
   reg hclk = 1'b0;
   reg hresetn = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   wire [31:0] hrdata;
   wire hready;
   wire hresp, irq, tx_load, rx_taken, rx_qr, tx_qr, ext_mode, loop_mode;
   wire rts_out, dtr_out, rx_valid, ovr, perr, ferr, brk, txr, txe;
   wire cts, dsr, dcd, ri;
   wire [7:0] tx_byte, rx_byte, qshadow, line_ctrl;
   wire [15:0] baud_divisor;
   integer failures = 0;
   integer cmp_count = 0;
   integer i;
   reg [7:0] q;
   always #4 hclk = ~hclk;
   buart_regs buart_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .irq(irq), .rx_byte(rx_byte), .rx_byte_valid(rx_valid),
      .rx_overrun(ovr), .rx_parity_err(perr), .rx_frame_err(ferr),
      .rx_break(brk), .tx_ready(txr), .tx_empty(txe), .cts_pin(cts),
      .dsr_pin(dsr), .dcd_pin(dcd), .ri_pin(ri), .tx_byte(tx_byte),
      .tx_load(tx_load), .rx_taken(rx_taken), .rx_queue_reset(rx_qr),
      .tx_queue_reset(tx_qr), .queue_ctrl_shadow(qshadow),
      .line_ctrl(line_ctrl), .baud_divisor(baud_divisor),
      .ext_mode(ext_mode), .loop_mode(loop_mode), .rts_out(rts_out),
      .dtr_out(dtr_out));
   buart_partner buart_partner_inst (.hclk(hclk), .tx_byte(tx_byte),
      .tx_load(tx_load), .rx_byte(rx_byte), .rx_byte_valid(rx_valid),
      .rx_overrun(ovr), .rx_parity_err(perr), .rx_frame_err(ferr),
      .rx_break(brk), .tx_ready(txr), .tx_empty(txe), .cts_pin(cts),
      .dsr_pin(dsr), .dcd_pin(dcd), .ri_pin(ri));
   task xfer(input w, input [31:0] a, input [7:0] d);
      begin
         haddr <= a;
         hwrite <= w;
         htrans <= 2'h2;
         hsel <= 1'b1;
         @(posedge hclk);
         while (hready !== 1'b1) @(posedge hclk);
         htrans <= 2'h0;
         hwdata <= {24'h0, d};
         @(posedge hclk);
         while (hready !== 1'b1) @(posedge hclk);
         q = hrdata[7:0];
      end
   endtask
   task wr(input [3:0] idx, input [7:0] d);
      xfer(1'b1, {26'h0, idx, 2'b00}, d);
   endtask
   task rd_chk(input [3:0] idx, input [7:0] e);
      begin
         xfer(1'b0, {26'h0, idx, 2'b00}, 8'h00);
         `CHK(q, e)
      end
   endtask
   task idle2;
      repeat (2) @(posedge hclk);
   endtask
   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      #40000;
      failures = failures + 1;
      end_sim;
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(4'h3, 8'h00);
      wr(4'h7, 8'h5A);
      rd_chk(4'h7, 8'h5A);
      wr(4'h3, 8'h1B);
      rd_chk(4'h3, 8'h1B);
      wr(4'h2, 8'hC7);
      rd_chk(4'h2, 8'hC1);
      wr(4'h3, 8'h80);
      rd_chk(4'h3, 8'h80);
      `CHK(line_ctrl, 8'h1B)
      wr(4'h0, 8'h34);
      wr(4'h1, 8'h12);
      rd_chk(4'h0, 8'h34);
      `CHK(baud_divisor, 16'h1234)
      wr(4'h3, 8'hC1);
      rd_chk(4'h1, 8'h12);
      wr(4'h3, 8'hE0);
      rd_chk(4'h0, 8'h00);
      wr(4'h0, 8'h78);
      wr(4'h1, 8'h56);
      rd_chk(4'h1, 8'h56);
      wr(4'h2, 8'h01);
      idle2;
      `CHK({ext_mode, baud_divisor}, 17'h15678)
      wr(4'h5, 8'hFF);
      rd_chk(4'h5, 8'h00);
      wr(4'h2, 8'h00);
      wr(4'h3, 8'hE4);
      rd_chk(4'h0, {`BUART_MODULE_ID, `BUART_REV_ID});
      rd_chk(4'h1, 8'h9B);
      rd_chk(4'h2, 8'hC7);
      for (i = 0; i < 4; i = i + 1) begin
         wr(4'h3, 8'hE8 + 8'h04 * i[7:0]);
         rd_chk(4'h3, 8'hE8 + 8'h04 * i[7:0]);
         rd_chk(4'h0, 8'h00);
      end
      wr(4'h3, 8'h03);
      rd_chk(4'h3, 8'h03);
      wr(4'h1, 8'h01);
      buart_partner_inst.send_rx(8'h3C);
      idle2;
      rd_chk(4'h8, 8'h01);
      `CHK(irq, 1'b0)
      wr(4'h9, 8'h01);
      idle2;
      `CHK(irq, 1'b1)
      rd_chk(4'h5, 8'h61);
      rd_chk(4'h0, 8'h3C);
      rd_chk(4'h5, 8'h60);
      wr(4'h8, 8'h01);
      idle2;
      `CHK(irq, 1'b0)
      buart_partner_inst.pulse_err(4'h2);
      idle2;
      rd_chk(4'h5, 8'hE4);
      rd_chk(4'h5, 8'h60);
      buart_partner_inst.set_modem(4'h1);
      repeat (4) idle2;
      rd_chk(4'h6, 8'h11);
      rd_chk(4'h6, 8'h10);
      wr(4'h0, 8'hA5);
      wr(4'h4, 8'h13);
      idle2;
      `CHK(buart_partner_inst.last_tx, 8'hA5)
      `CHK({loop_mode, rts_out, dtr_out}, 3'b111)
      xfer(1'b1, 32'h40, 8'hFF);
      xfer(1'b0, 32'h40, 8'h00);
      `CHK(q, 8'h00)
      idle2;
      end_sim;
   end
endmodule
